// >>> rtl/ettc_pkg.sv
// Purpose: shared constants, register map and carrier types of the trigger/trace control
// Assumes: 32-bit APB, one aligned word per register
// Notes: all offsets are byte addresses
package ettc_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0] CTRL_OFF = 8'h00;     // mode and break options
  localparam logic [7:0] EVT_ON_OFF = 8'h04;   // range-start address
  localparam logic [7:0] EVT_OFF_OFF = 8'h08;  // range-stop address
  localparam logic [7:0] EVT_HIT_OFF = 8'h0C;  // single-address hit address
  localparam logic [7:0] PERI_OFF = 8'h10;     // peripheral options
  localparam logic [7:0] STAT_OFF = 8'h14;     // read-only sticky status
  localparam logic [7:0] ICLR_OFF = 8'h18;     // write-one-to-clear status
  localparam logic [7:0] IEN_OFF = 8'h1C;      // interrupt enable
  localparam logic [7:0] LIVE_OFF = 8'h20;     // live block state
  localparam logic [7:0] PRESC_OFF = 8'h24;    // timer prescaler divisor

  // =====================================================================
  // control register fields
  localparam int CTRL_FILT_BIT = 0;      // trace filtering enable
  localparam int CTRL_MODE_BIT = 1;      // 0 range pair, 1 single hit
  localparam int CTRL_SIG_LSB = 2;       // 2-bit output signalling variant
  localparam int CTRL_BRK_TRIG_BIT = 4;  // break on trigger input
  localparam int CTRL_BRK_OVF_BIT = 5;   // break on trace overflow
  localparam int CTRL_RESUME_BIT = 6;    // write 1: release the stop

  // peripheral option fields
  localparam int PERI_TA_RUN_BIT = 0;    // timer A runs through a stop
  localparam int PERI_TB_RUN_BIT = 1;    // timer B runs through a stop
  localparam int PERI_PWM_RUN_BIT = 2;   // pwm runs through a stop
  localparam int PERI_HALT_RST_BIT = 3;  // halt with watchdog resets chip
  localparam int PERI_WDG_HW_BIT = 4;    // watchdog enabled by hardware
  localparam int PERI_SLOW_BIT = 5;      // slow clock mode
  localparam int PERI_CLK_EXT_BIT = 6;   // core clock from external inlet

  // status / interrupt bits
  localparam int ST_TRIG_BIT = 0;        // trigger-input break
  localparam int ST_OVF_BIT = 1;         // trace overflow break
  localparam int ST_HIT_BIT = 2;         // single-address hit seen
  localparam int ST_RST_BIT = 3;         // halt-watchdog reset issued
  localparam int ST_W = 4;

  // =====================================================================
  // reset values and limits
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PERI_RST = 32'h0000_0000;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  localparam logic [15:0] TRACE_VALID_ADDR = 16'h2000;  // valid above this
  localparam int RST_PULSE_CYC = 4;                     // chip reset width

  // output signalling variants
  typedef enum logic [1:0] {ETTC_SIG_LEVEL, ETTC_SIG_RISE, ETTC_SIG_FALL, ETTC_SIG_PULSE}
    ettc_sig_t;

  // one bus access of the emulated core
  typedef struct packed {
    logic        valid;  // access strobe this cycle
    logic [15:0] addr;   // accessed address
  } ettc_core_acc_t;

  // probe-side trace sideband
  typedef struct packed {
    logic       trig_valid;  // trigger-input/probe bits valid
    logic       trig_in;     // sampled trigger input
    logic [2:0] probe;       // sampled probe bits
  } ettc_trace_side_t;

endpackage

// >>> rtl/ettc_top.sv
// Functional notes
// - range-start address turns range event on
// - range-stop address turns range event off
// - hit event only during matching access cycles
// - filtering on gates trace by events
// - trigger output follows range or hit
// - trigger-input rise stops after current instruction
// - trace full stops program when enabled
// - trigger/probe trace bits valid above 2000H
// - timers: 16-bit counter with prescaler, compare, pwm, capture
// - timer run option decides freeze at stop
// - first timer external clock never frozen
// - pwm offers same run-or-freeze option
// - halt with watchdog resets when selected
// - watchdog enable source selectable
// - core clock from on-board or inlet only
//
// Purpose: emulator debug control: event qualify, trigger, trace gate, break, peripheral options
// Assumes: single clock clk, APB slave, core and probe inputs synchronous to clk
// Notes: timers are shown by their freeze/run enables; capture/compare live in the timer block
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module ettc_top #(
  parameter int ADDR_W = 16  // core address width
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // emulated core
  input wire ettc_pkg::ettc_core_acc_t core_acc,
  input wire logic instr_done,
  input wire logic halt_exec,
  input wire logic wdg_active,
  input wire logic trace_full,
  // external pins
  input wire logic external_trigger_input,
  input wire logic first_timer_external_clock,
  input wire logic [2:0] probe_in,
  output logic external_trigger_output,
  // trace and stop
  output logic trace_record,
  output ettc_pkg::ettc_trace_side_t trace_side,
  output logic core_stop,
  output logic chip_reset,
  // peripheral controls
  output logic timer_a_run,
  output logic timer_b_run,
  output logic pwm_run,
  output logic timer_a_ext_clk,
  output logic timer_presc_tick,
  output logic wdg_hw_enable,
  output logic slow_mode,
  output logic clk_sel_ext,
  output logic irq
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [31:0] ctrl;        // control register
    logic [31:0] peri;        // peripheral options
    logic [ADDR_W-1:0] a_on;  // range start address
    logic [ADDR_W-1:0] a_off; // range stop address
    logic [ADDR_W-1:0] a_hit; // hit address
    logic [15:0] presc;       // prescaler divisor
    logic [15:0] pcnt;        // prescaler counter
    logic [ettc_pkg::ST_W-1:0] stat;  // sticky status
    logic [ettc_pkg::ST_W-1:0] ien;   // interrupt enable
    logic range_act;          // range event state
    logic ev_prev;            // previous selected event
    logic trig_prev;          // previous trigger input
    logic brk_pend;           // break waits for instruction end
    logic stop;               // program stopped
    logic [2:0] rcnt;         // chip reset pulse counter
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trig_out;
    logic trace_rec;
    ettc_pkg::ettc_trace_side_t side;
    logic presc_tick;
    logic irq;
    logic ta_run;             // timer A run gate
    logic tb_run;             // timer B run gate
    logic pwm_run;            // pwm run gate
    logic ext_clk;            // timer A external clock copy, never gated
    logic rst_out;            // chip reset output
  } ettc_state_t;

  ettc_state_t state_reg;     // registered state
  ettc_state_t state_next;    // next state
  logic [1:0] rst_sync_reg;   // reset release synchroniser
  logic rst_n;                // synchronised reset

  // =====================================================================
  // reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // =====================================================================
  // next state
  always_comb
  begin
    logic hit;        // single-address event this cycle
    logic on_hit;     // access at range start
    logic off_hit;    // access at range stop
    logic ev;         // selected event for output and trace
    logic wr;         // apb write access phase
    logic rd;         // apb read access phase
    logic [ettc_pkg::ST_W-1:0] set_v;  // status set events
    logic [ettc_pkg::ST_W-1:0] clr_v;  // status clear requests
    ettc_pkg::ettc_sig_t sig;          // output variant
    // locals start from a known value on every pass
    hit = 1'b0;
    on_hit = 1'b0;
    off_hit = 1'b0;
    ev = 1'b0;
    state_next = state_reg;
    wr = psel && penable && pwrite && !state_reg.pready;
    rd = psel && penable && !pwrite && !state_reg.pready;
    set_v = '0;
    clr_v = '0;
    sig = ettc_pkg::ettc_sig_t'(state_reg.ctrl[ettc_pkg::CTRL_SIG_LSB +: 2]);

    // address qualifiers
    hit = core_acc.valid && (core_acc.addr[ADDR_W-1:0] == state_reg.a_hit);
    on_hit = core_acc.valid && (core_acc.addr[ADDR_W-1:0] == state_reg.a_on);
    off_hit = core_acc.valid && (core_acc.addr[ADDR_W-1:0] == state_reg.a_off);
    // range event: stop wins if both match in one cycle
    if (off_hit)
      state_next.range_act = 1'b0;
    else if (on_hit)
      state_next.range_act = 1'b1;

    // event selection for the trigger output
    if (state_reg.ctrl[ettc_pkg::CTRL_MODE_BIT])
      ev = hit;
    else
      // range as it stands after this access: on at the start, off at the stop access
      ev = state_next.range_act;
    state_next.ev_prev = ev;

    // output signalling variant
    unique case (sig)
      ettc_pkg::ETTC_SIG_LEVEL: state_next.trig_out = ev;
      ettc_pkg::ETTC_SIG_RISE: state_next.trig_out = ev && !state_reg.ev_prev;
      ettc_pkg::ETTC_SIG_FALL: state_next.trig_out = !ev && state_reg.ev_prev;
      ettc_pkg::ETTC_SIG_PULSE: state_next.trig_out = ev ^ state_reg.ev_prev;
    endcase

    // trace gating
    if (state_reg.ctrl[ettc_pkg::CTRL_FILT_BIT])
      state_next.trace_rec = ev && !state_reg.stop;
    else
      state_next.trace_rec = !state_reg.stop;
    // trace sideband validity
    state_next.side.trig_valid = core_acc.addr > ettc_pkg::TRACE_VALID_ADDR;
    state_next.side.trig_in = external_trigger_input;
    state_next.side.probe = probe_in;

    // break on trigger input rising edge, taken at instruction end
    state_next.trig_prev = external_trigger_input;
    if (state_reg.ctrl[ettc_pkg::CTRL_BRK_TRIG_BIT] && external_trigger_input
        && !state_reg.trig_prev)
      state_next.brk_pend = 1'b1;
    if (state_next.brk_pend && instr_done)
    begin
      state_next.brk_pend = 1'b0;
      state_next.stop = 1'b1;
      set_v[ettc_pkg::ST_TRIG_BIT] = 1'b1;
    end
    // break on trace overflow
    if (state_reg.ctrl[ettc_pkg::CTRL_BRK_OVF_BIT] && trace_full && !state_reg.stop)
    begin
      state_next.stop = 1'b1;
      set_v[ettc_pkg::ST_OVF_BIT] = 1'b1;
    end
    if (hit)
      set_v[ettc_pkg::ST_HIT_BIT] = 1'b1;

    // halt with watchdog reset
    if (state_reg.rcnt != 3'h0)
      state_next.rcnt = state_reg.rcnt - 3'h1;
    else if (halt_exec && wdg_active && state_reg.peri[ettc_pkg::PERI_HALT_RST_BIT])
    begin
      state_next.rcnt = 3'(ettc_pkg::RST_PULSE_CYC);
      set_v[ettc_pkg::ST_RST_BIT] = 1'b1;
    end

    // timer prescaler, frozen at a stop unless timer A runs
    if (!state_reg.stop || state_reg.peri[ettc_pkg::PERI_TA_RUN_BIT])
    begin
      if (state_reg.pcnt >= state_reg.presc)
      begin
        state_next.pcnt = 16'h0000;
        state_next.presc_tick = 1'b1;
      end
      else
      begin
        state_next.pcnt = state_reg.pcnt + 16'h0001;
        state_next.presc_tick = 1'b0;
      end
    end
    else
      state_next.presc_tick = 1'b0;

    // apb access
    state_next.pready = psel && penable && !state_reg.pready;
    state_next.pslverr = 1'b0;
    state_next.prdata = 32'h0000_0000;
    if (wr)
    begin
      unique case (paddr)
        ettc_pkg::CTRL_OFF:
        begin
          state_next.ctrl = {25'h0, 1'b0, pwdata[5:0]};
          // a break raised in the same cycle wins over the resume
          if (pwdata[ettc_pkg::CTRL_RESUME_BIT] && !set_v[ettc_pkg::ST_TRIG_BIT]
              && !set_v[ettc_pkg::ST_OVF_BIT])
            state_next.stop = 1'b0;
        end
        ettc_pkg::EVT_ON_OFF: state_next.a_on = pwdata[ADDR_W-1:0];
        ettc_pkg::EVT_OFF_OFF: state_next.a_off = pwdata[ADDR_W-1:0];
        ettc_pkg::EVT_HIT_OFF: state_next.a_hit = pwdata[ADDR_W-1:0];
        ettc_pkg::PERI_OFF: state_next.peri = {25'h0, pwdata[6:0]};
        ettc_pkg::ICLR_OFF: clr_v = pwdata[ettc_pkg::ST_W-1:0];
        ettc_pkg::IEN_OFF: state_next.ien = pwdata[ettc_pkg::ST_W-1:0];
        ettc_pkg::PRESC_OFF: state_next.presc = pwdata[15:0];
        ettc_pkg::STAT_OFF, ettc_pkg::LIVE_OFF: ;
        default: state_next.pslverr = 1'b1;
      endcase
    end
    else if (rd)
    begin
      unique case (paddr)
        ettc_pkg::CTRL_OFF: state_next.prdata = state_reg.ctrl;
        ettc_pkg::EVT_ON_OFF: state_next.prdata = 32'(state_reg.a_on);
        ettc_pkg::EVT_OFF_OFF: state_next.prdata = 32'(state_reg.a_off);
        ettc_pkg::EVT_HIT_OFF: state_next.prdata = 32'(state_reg.a_hit);
        ettc_pkg::PERI_OFF: state_next.prdata = state_reg.peri;
        ettc_pkg::STAT_OFF: state_next.prdata = 32'(state_reg.stat);
        ettc_pkg::IEN_OFF: state_next.prdata = 32'(state_reg.ien);
        ettc_pkg::LIVE_OFF:
          state_next.prdata = {28'h0, state_reg.brk_pend, state_reg.stop,
                               state_reg.trig_out, state_reg.range_act};
        ettc_pkg::PRESC_OFF: state_next.prdata = {16'h0, state_reg.presc};
        ettc_pkg::ICLR_OFF: ;
        default: state_next.pslverr = 1'b1;
      endcase
    end

    // sticky status: set wins over clear
    state_next.stat = (state_reg.stat & ~clr_v) | set_v;
    state_next.irq = |(state_next.stat & state_next.ien);

    // peripheral gates from the next state, so the outputs stay in step with stop
    state_next.ta_run = !state_next.stop || state_next.peri[ettc_pkg::PERI_TA_RUN_BIT];
    state_next.tb_run = !state_next.stop || state_next.peri[ettc_pkg::PERI_TB_RUN_BIT];
    state_next.pwm_run = !state_next.stop || state_next.peri[ettc_pkg::PERI_PWM_RUN_BIT];
    // external timer clock is copied whatever the stop state
    state_next.ext_clk = first_timer_external_clock;
    state_next.rst_out = state_next.rcnt != 3'h0;
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.ctrl <= ettc_pkg::CTRL_RST;
      state_reg.peri <= ettc_pkg::PERI_RST;
      state_reg.presc <= ettc_pkg::PRESC_RST;
      // not stopped in reset, so every peripheral runs
      state_reg.ta_run <= 1'b1;
      state_reg.tb_run <= 1'b1;
      state_reg.pwm_run <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // =====================================================================
  // outputs, all straight from flip-flops
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign external_trigger_output = state_reg.trig_out;
  assign trace_record = state_reg.trace_rec;
  assign trace_side = state_reg.side;
  assign core_stop = state_reg.stop;
  assign chip_reset = state_reg.rst_out;
  assign timer_a_run = state_reg.ta_run;
  assign timer_b_run = state_reg.tb_run;
  assign pwm_run = state_reg.pwm_run;
  assign timer_a_ext_clk = state_reg.ext_clk;
  assign timer_presc_tick = state_reg.presc_tick;
  assign wdg_hw_enable = state_reg.peri[ettc_pkg::PERI_WDG_HW_BIT];
  assign slow_mode = state_reg.peri[ettc_pkg::PERI_SLOW_BIT];
  assign clk_sel_ext = state_reg.peri[ettc_pkg::PERI_CLK_EXT_BIT];
  assign irq = state_reg.irq;

endmodule // ettc_top

// >>> tb/ettc_props.sv
// Purpose: port-level properties of the trigger/trace control
// Assumes: one clock, async active-low reset
// Notes: bound to every ettc_top instance
`timescale 1ns/1ps
module ettc_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire ettc_pkg::ettc_core_acc_t core_acc,
  input wire logic instr_done,
  input wire logic halt_exec,
  input wire logic wdg_active,
  input wire logic trace_full,
  // pins and outputs
  input wire logic external_trigger_input,
  input wire logic first_timer_external_clock,
  input wire logic [2:0] probe_in,
  input wire logic timer_a_ext_clk,
  input wire ettc_pkg::ettc_trace_side_t trace_side,
  input wire logic core_stop,
  input wire logic chip_reset,
  input wire logic timer_a_run,
  input wire logic timer_b_run,
  input wire logic pwm_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // properties
  property p_ext_clk;
    1'h1 |=> timer_a_ext_clk == $past(first_timer_external_clock);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("timer A clock frozen");
  property p_side;
    1'h1 |=> trace_side.probe == $past(probe_in)
      && trace_side.trig_in == $past(external_trigger_input);
  endproperty
  a_side: assert property (p_side) else $error("trace sideband wrong");
  property p_tv_lo;
    core_acc.valid && core_acc.addr <= 16'h2000 |=> !trace_side.trig_valid;
  endproperty
  a_tv_lo: assert property (p_tv_lo) else $error("low address marked valid");
  property p_tv_hi;
    core_acc.valid && core_acc.addr > 16'h2000 |=> trace_side.trig_valid;
  endproperty
  a_tv_hi: assert property (p_tv_hi) else $error("high address not valid");
  property p_stop_rise; $rose(core_stop) |-> $past(instr_done) || $past(trace_full); endproperty
  a_stop_rise: assert property (p_stop_rise) else $error("stop without cause");
  property p_stop_fall; $fell(core_stop) |-> $past(psel && penable && pwrite); endproperty
  a_stop_fall: assert property (p_stop_fall) else $error("stop dropped without write");
  property p_run; !core_stop |-> timer_a_run && timer_b_run && pwm_run; endproperty
  a_run: assert property (p_run) else $error("timer halted while running");
  property p_rst_why; $rose(chip_reset) |-> $past(halt_exec) && $past(wdg_active); endproperty
  a_rst_why: assert property (p_rst_why) else $error("chip reset without halt");
  property p_rst_len; $rose(chip_reset) |-> chip_reset [*4] ##1 !chip_reset; endproperty
  a_rst_len: assert property (p_rst_len) else $error("chip reset width");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than a cycle");
  // main scenarios reached
  c_stop: cover property ($rose(core_stop));
  c_rst: cover property ($rose(chip_reset));
  c_err: cover property (pslverr && pready);
endmodule // ettc_props
bind ettc_top ettc_props u_props (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .core_acc(core_acc),
  .instr_done(instr_done), .halt_exec(halt_exec), .wdg_active(wdg_active),
  .trace_full(trace_full), .external_trigger_input(external_trigger_input),
  .first_timer_external_clock(first_timer_external_clock), .probe_in(probe_in),
  .timer_a_ext_clk(timer_a_ext_clk), .trace_side(trace_side), .core_stop(core_stop),
  .chip_reset(chip_reset), .timer_a_run(timer_a_run), .timer_b_run(timer_b_run),
  .pwm_run(pwm_run));

// >>> tb/ettc_top_tb_top.sv
// Purpose: self-checking bench of the trigger/trace control
// Assumes: 50 MHz clock, APB master tasks
// Notes: expectations built from package constants
`timescale 1ns/1ps
module ettc_top_tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, fire = 1'h0, ext_trig, instr_done = 1'h0, halt_exec = 1'h0;
  logic wdg_active = 1'h0, trace_full = 1'h0, trig_out, trace_record, core_stop, chip_reset;
  logic ta_run, tb_run, pwm_run, wdg_hw, irq, tick, slow, clk_ext;
  logic [2:0] probe_in = 3'h0;
  ettc_pkg::ettc_core_acc_t core_acc = '0;
  int err_total = 0, n_checks = 0, cyc = 0, hi;
  // ==========================================================
  // clock, trigger equipment, design
  initial forever #10 clk = ~clk;
  ettc_trig_src u_src (.clk(clk), .fire(fire), .external_trigger_input(ext_trig));
  ettc_top dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_acc(core_acc), .instr_done(instr_done), .halt_exec(halt_exec),
    .wdg_active(wdg_active), .trace_full(trace_full), .external_trigger_input(ext_trig),
    .first_timer_external_clock(cyc[2]), .probe_in(probe_in),
    .external_trigger_output(trig_out), .trace_record(trace_record), .trace_side(),
    .core_stop(core_stop), .chip_reset(chip_reset), .timer_a_run(ta_run),
    .timer_b_run(tb_run), .pwm_run(pwm_run), .timer_a_ext_clk(), .timer_presc_tick(tick),
    .wdg_hw_enable(wdg_hw), .slow_mode(slow), .clk_sel_ext(clk_ext), .irq(irq));
  // ==========================================================
  // one APB transfer, held until ready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // ready and read data are taken at the rising edge that ends the access
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one core access cycle, then settle on the following cycle
  task automatic acc(input logic [15:0] a);
    @(posedge clk);
    core_acc <= '{valid: 1'h1, addr: a};
    @(posedge clk);
    core_acc <= '{valid: 1'h0, addr: a};
    @(negedge clk);
  endtask
  // one-cycle strobe of halt or instruction end
  task automatic strobe(input logic h);
    @(posedge clk);
    if (h)
      halt_exec <= 1'h1;
    else
      instr_done <= 1'h1;
    @(posedge clk);
    halt_exec <= 1'h0;
    instr_done <= 1'h0;
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cycle count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    probe_in <= 3'h5;
    apb(ettc_pkg::CTRL_OFF, 1'h0, 32'h0);
    chk(rdat, ettc_pkg::CTRL_RST);
    apb(8'h30, 1'h0, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(ettc_pkg::PRESC_OFF, 1'h1, 32'h2);
    apb(ettc_pkg::PRESC_OFF, 1'h0, 32'h0);
    chk(rdat, 32'h2);
    $display("end of register test");
    // single hit with trace filtering, then filtering off
    apb(ettc_pkg::EVT_HIT_OFF, 1'h1, 32'h2345);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h3);
    acc(16'h2345);
    chk(32'(trig_out), 32'h1);
    chk(32'(trace_record), 32'h1);
    @(negedge clk);
    chk(32'(trig_out), 32'h0);
    chk(32'(trace_record), 32'h0);
    acc(16'h2346);
    chk(32'(trig_out), 32'h0);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h2);
    acc(16'h0100);
    chk(32'(trace_record), 32'h1);
    $display("end of hit test");
    // range pair drives the output
    apb(ettc_pkg::EVT_ON_OFF, 1'h1, 32'h3000);
    apb(ettc_pkg::EVT_OFF_OFF, 1'h1, 32'h3100);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h0);
    acc(16'h3000);
    chk(32'(trig_out), 32'h1);
    acc(16'h3050);
    chk(32'(trig_out), 32'h1);
    acc(16'h3100);
    chk(32'(trig_out), 32'h0);
    // rise variant: one cycle at the start; pulse variant: one cycle at each edge, checked at the end
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h4);
    acc(16'h3000);
    chk(32'(trig_out), 32'h1);
    @(negedge clk);
    chk(32'(trig_out), 32'h0);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'hC);
    acc(16'h3100);
    chk(32'(trig_out), 32'h1);
    $display("end of range test");
    // trigger-input break waits for the instruction end
    apb(ettc_pkg::ICLR_OFF, 1'h1, 32'hF);
    apb(ettc_pkg::IEN_OFF, 1'h1, 32'hF);
    apb(ettc_pkg::PERI_OFF, 1'h1, 32'h1);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h10);
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    repeat (3) @(negedge clk);
    chk(32'(core_stop), 32'h0);
    strobe(1'h0);
    repeat (2) @(negedge clk);
    chk(32'(core_stop), 32'h1);
    chk({29'h0, ta_run, tb_run, pwm_run}, 32'h4);
    chk(32'(irq), 32'h1);
    apb(ettc_pkg::STAT_OFF, 1'h0, 32'h0);
    chk(rdat, 32'h1);
    apb(ettc_pkg::ICLR_OFF, 1'h1, 32'h1);
    apb(ettc_pkg::STAT_OFF, 1'h0, 32'h0);
    chk({rdat[30:0], irq}, 32'h0);
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h50);
    @(negedge clk);
    chk(32'(core_stop), 32'h0);
    $display("end of trigger break test");
    // trace overflow break
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h20);
    trace_full <= 1'h1;
    repeat (2) @(negedge clk);
    chk(32'(core_stop), 32'h1);
    apb(ettc_pkg::STAT_OFF, 1'h0, 32'h0);
    chk(rdat, 32'h2);
    // stopped: prescaler ticks every third cycle while timer A runs, none once frozen
    for (int k = 0; k < 2; k++)
    begin
      hi = 0;
      repeat (9) @(negedge clk) if (tick === 1'h1) hi++;
      chk(32'(hi), (k == 0) ? 32'h3 : 32'h0);
      apb(ettc_pkg::PERI_OFF, 1'h1, 32'h0);
    end
    trace_full <= 1'h0;
    apb(ettc_pkg::CTRL_OFF, 1'h1, 32'h60);
    $display("end of overflow test");
    // halt with watchdog, reset and no-reset options
    apb(ettc_pkg::PERI_OFF, 1'h1, 32'h78);
    chk({29'h0, wdg_hw, slow, clk_ext}, 32'h7);
    wdg_active <= 1'h1;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        apb(ettc_pkg::PERI_OFF, 1'h1, 32'h0);
      strobe(1'h1);
      hi = 0;
      repeat (8) @(negedge clk) if (chip_reset === 1'h1) hi++;
      chk(32'(hi), (k == 0) ? 32'(ettc_pkg::RST_PULSE_CYC) : 32'h0);
    end
    chk({29'h0, wdg_hw, slow, clk_ext}, 32'h0);
    $display("end of halt test");
    report_and_stop();
  end
endmodule // ettc_top_tb_top

// >>> tb/ettc_trig_src.sv
// Purpose: external trigger equipment driving the trigger inlet
// Assumes: commanded from the bench clock
// Notes: holds the level three cycles, then returns low
`timescale 1ns/1ps
module ettc_trig_src (
  // clock and command
  input wire logic clk,
  input wire logic fire,
  // trigger pin
  output logic external_trigger_input
);
  logic [1:0] hold_reg = 2'h0; // cycles left high
  // raise on command, drop when the hold runs out
  always @(posedge clk)
  begin
    if (fire)
      hold_reg <= 2'h3;
    else if (hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
  end
  assign external_trigger_input = (hold_reg != 2'h0);
endmodule // ettc_trig_src
